/* File: src/rsrep_core.sv */
// Direction control for a two-sided half-duplex RS-485 repeater
`timescale 1ns/100ps
`default_nettype none
module rsrep_core import rsrep_pkg::*; #(
	parameter int unsigned CLK_FREQ = CLK_HZ
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic rx_a_i,
	input wire logic rx_b_i,
	input wire logic [SEL_W-1:0] baud_sel_i,
	output logic drv_en_a_o,
	output logic drv_en_b_o,
	output logic tx_a_o,
	output logic tx_b_o,
	output logic [CNT_W-1:0] remain_o
);
	// Character length in clock cycles for each selector position, from the bit time rounded down
	logic [CNT_W-1:0] char_cycles [NUM_RATES];
	genvar g;
	generate
		for (g = 0; g < NUM_RATES; g++) begin : g_rate
			assign char_cycles[g] = CNT_W'((CLK_FREQ / BAUD_TABLE[g]) * FRAME_BITS);
		end
	endgenerate

	// Direction state, character counter, line history and registered pin drive
	rsrep_state_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic rxa_prev_q, rxb_prev_q;
	logic rxa_prev_d, rxb_prev_d;
	rsrep_line_s out_q, out_d;
	logic fall_a, fall_b;

	// Start-bit detection is pure line activity on each side
	assign fall_a = rxa_prev_q & ~rx_a_i;
	assign fall_b = rxb_prev_q & ~rx_b_i;

	// Line history for the start detectors, one sample per clock
	always_comb begin
		rxa_prev_d = rx_a_i;
		rxb_prev_d = rx_b_i;
	end

	// Next-state, counter and forwarding path
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		// Default is receive mode on both sides with idle-high lines
		out_d.drv_a = 1'b0;
		out_d.drv_b = 1'b0;
		out_d.tx_a = LINE_IDLE;
		out_d.tx_b = LINE_IDLE;
		case (state_q)
			ST_IDLE: begin
				if (fall_a) begin // A has priority on a simultaneous start
					state_d = ST_A2B;
					cnt_d = char_cycles[baud_sel_i] - 20'h00001;
					out_d.drv_b = 1'b1;
					out_d.tx_b = rx_a_i;
				end else if (fall_b) begin
					state_d = ST_B2A;
					cnt_d = char_cycles[baud_sel_i] - 20'h00001;
					out_d.drv_a = 1'b1;
					out_d.tx_a = rx_b_i;
				end
			end
			ST_A2B: begin
				// B-side starts are not looked at here, so our own output is not echoed
				if (cnt_q == CNT_ZERO) begin
					state_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q - 20'h00001;
					out_d.drv_b = 1'b1;
					out_d.tx_b = rx_a_i;
				end
			end
			// Mirror of A to B; A-side starts here are our own echo
			ST_B2A: begin
				if (cnt_q == CNT_ZERO) begin
					state_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q - 20'h00001;
					out_d.drv_a = 1'b1;
					out_d.tx_a = rx_b_i;
				end
			end
			// Any stray code falls back to receive mode
			default: begin
				state_d = ST_IDLE;
				cnt_d = CNT_ZERO;
			end
		endcase
	end

	// State registers, synchronous reset to receive mode
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			cnt_q <= CNT_ZERO;
			rxa_prev_q <= LINE_IDLE;
			rxb_prev_q <= LINE_IDLE;
			out_q <= '{drv_a: 1'b0, drv_b: 1'b0, tx_a: LINE_IDLE, tx_b: LINE_IDLE};
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			rxa_prev_q <= rxa_prev_d;
			rxb_prev_q <= rxb_prev_d;
			out_q <= out_d;
		end
	end

	// Ports come straight from the output and counter flops
	assign drv_en_a_o = out_q.drv_a;
	assign drv_en_b_o = out_q.drv_b;
	assign tx_a_o = out_q.tx_a;
	assign tx_b_o = out_q.tx_b;
	assign remain_o = cnt_q;

	// Checks on the direction logic
	AST_IDLE_QUIET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_IDLE) |-> (!out_q.drv_a && !out_q.drv_b))
		else $error("driver on while idle");
	AST_START_A: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_IDLE && fall_a) |=> (drv_en_b_o && !drv_en_a_o))
		else $error("start on A did not enable B");
	AST_START_B: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_IDLE && !fall_a && fall_b) |=> (drv_en_a_o && !drv_en_b_o))
		else $error("start on B did not enable A");
	AST_HOLD_END: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q != ST_IDLE && cnt_q == CNT_ZERO) |=> (state_q == ST_IDLE && !drv_en_a_o && !drv_en_b_o))
		else $error("driver not released at end of character");
	AST_LOAD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_IDLE && (fall_a || fall_b)) |=> (cnt_q == $past(char_cycles[baud_sel_i]) - 20'h00001))
		else $error("character count not loaded from selector");
	AST_FWD_A2B: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_d == ST_A2B) |=> (tx_b_o == $past(rx_a_i)))
		else $error("A to B data not forwarded");
	AST_FWD_B2A: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_d == ST_B2A) |=> (tx_a_o == $past(rx_b_i)))
		else $error("B to A data not forwarded");
	AST_NO_ECHO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_A2B && cnt_q != CNT_ZERO) |=> (state_q == ST_A2B))
		else $error("direction changed mid character");
	AST_COUNT_DOWN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q != ST_IDLE && cnt_q != CNT_ZERO) |=> (cnt_q == $past(cnt_q) - 20'h00001))
		else $error("character counter not stepping");

	// Own echo on the driven side never moves the direction
	AST_NO_ECHO_B: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_B2A && cnt_q != CNT_ZERO)
		|=> (state_q == ST_B2A))
		else $error("direction changed mid character on B");
	AST_ECHO_B_IGNORED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_A2B && cnt_q != CNT_ZERO && fall_b)
		|=> (drv_en_b_o && !drv_en_a_o))
		else $error("echo on B disturbed the A to B character");
	AST_ECHO_A_IGNORED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_B2A && cnt_q != CNT_ZERO && fall_a)
		|=> (drv_en_a_o && !drv_en_b_o))
		else $error("echo on A disturbed the B to A character");

	// Start arbitration and holding the far driver
	AST_TIE_A_WINS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_IDLE && fall_a && fall_b)
		|=> (drv_en_b_o && !drv_en_a_o))
		else $error("simultaneous start not given to A");
	AST_ONE_DRIVER: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(drv_en_a_o || drv_en_b_o)
		|-> (drv_en_a_o != drv_en_b_o))
		else $error("both drivers on together");
	AST_A2B_DRIVE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_A2B)
		|-> (drv_en_b_o && !drv_en_a_o))
		else $error("B driver off during A to B character");
	AST_B2A_DRIVE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_B2A)
		|-> (drv_en_a_o && !drv_en_b_o))
		else $error("A driver off during B to A character");

	// Receive mode and idle lines whenever a driver is off
	AST_TX_A_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!drv_en_a_o)
		|-> tx_a_o)
		else $error("A data not idle while its driver is off");
	AST_TX_B_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!drv_en_b_o)
		|-> tx_b_o)
		else $error("B data not idle while its driver is off");
	AST_REMAIN_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_IDLE)
		|-> (remain_o == CNT_ZERO))
		else $error("count left over while idle");
	AST_IDLE_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_IDLE && !fall_a && !fall_b)
		|=> (state_q == ST_IDLE && !drv_en_a_o && !drv_en_b_o))
		else $error("left idle without line activity");

	// Character length and release
	AST_LOAD_NONZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q == ST_IDLE && (fall_a || fall_b))
		|=> (remain_o != CNT_ZERO))
		else $error("empty character period loaded");
	AST_END_TX_HIGH: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(state_q != ST_IDLE && cnt_q == CNT_ZERO)
		|=> (tx_a_o && tx_b_o && remain_o == CNT_ZERO))
		else $error("lines not idle after release");

	// Reset puts both sides back into receive mode
	AST_RESET_QUIET: assert property (@(posedge clock_i)
		(!rst_n_i)
		|=> (!drv_en_a_o && !drv_en_b_o && tx_a_o && tx_b_o && remain_o == CNT_ZERO))
		else $error("block not quiet after reset");
endmodule : rsrep_core
`default_nettype wire

/* File: src/rsrep_pkg.sv */
// Package of constants and types for the half-duplex RS-485 repeater direction logic
`default_nettype none
package rsrep_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned FRAME_BITS = 10;
	localparam int unsigned NUM_RATES = 8;
	localparam int unsigned SEL_W = 3;
	localparam int unsigned CNT_W = 20;
	localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
	localparam logic [SEL_W-1:0] SEL_RST = 3'h4;
	localparam logic LINE_IDLE = 1'b1;
	typedef int unsigned rsrep_rate_t [NUM_RATES];
	localparam rsrep_rate_t BAUD_TABLE = '{600, 1200, 2400, 4800, 9600, 19200, 38400, 76800};
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_A2B = 3'b010,
		ST_B2A = 3'b100
	} rsrep_state_e;
	typedef struct packed {
		logic drv_a;
		logic drv_b;
		logic tx_a;
		logic tx_b;
	} rsrep_line_s;
endpackage : rsrep_pkg
`default_nettype wire

/* File: sim/rsrep_node.sv */
// Bus node model that sends one start, eight data, stop character on its line
`timescale 1ns/100ps
`default_nettype none
module rsrep_node (
	input wire logic clock_i,
	input wire logic go_i,
	input wire logic [7:0] data_i,
	input wire logic [15:0] bit_len_i,
	output logic line_o
);
	// Frame shifter, LSB first, no direction line towards the repeater
	initial begin
		line_o = 1'b1;
		forever begin
			@(posedge clock_i);
			if (go_i) begin
				@(negedge clock_i);
				for (int b = 0; b < 10; b++) begin
					line_o = (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : data_i[b-1];
					repeat (bit_len_i) @(negedge clock_i);
				end
			end
		end
	end
endmodule : rsrep_node
`default_nettype wire

/* File: sim/rsrep_core_tb.sv */
// Self-checking bench for the repeater direction logic
`timescale 1ns/100ps
`default_nettype none
module rsrep_core_tb;
	import rsrep_pkg::*;
	localparam int unsigned FREQ = 768000;
	logic clock_i, rst_n_i, go_a, go_b, dir, src_q, line_a, line_b, en_a, en_b, tx_a, tx_b;
	logic [SEL_W-1:0] sel;
	logic [15:0] len;
	logic [CNT_W-1:0] remain;
	int fail_count, checked;
	// Each bus line also carries the repeater's own driven bits, so echoes reach its receivers
	wire logic rx_a = line_a & (tx_a | ~en_a);
	wire logic rx_b = line_b & (tx_b | ~en_b);
	rsrep_core #(.CLK_FREQ(FREQ)) rsrep_core_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .rx_a_i(rx_a),
		.rx_b_i(rx_b), .baud_sel_i(sel), .drv_en_a_o(en_a), .drv_en_b_o(en_b), .tx_a_o(tx_a),
		.tx_b_o(tx_b), .remain_o(remain));
	rsrep_node node_a_i (.clock_i(clock_i), .go_i(go_a), .data_i(8'hA5), .bit_len_i(len), .line_o(line_a));
	rsrep_node node_b_i (.clock_i(clock_i), .go_i(go_b), .data_i(8'h3C), .bit_len_i(len), .line_o(line_b));
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	// Origin line as the design saw it at the last edge
	always @(posedge clock_i) src_q <= dir ? rx_b : rx_a;
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask : cmp
	// One character from one side, with the far driver timed and its data followed
	task automatic xfer(input logic b2a, input logic [SEL_W-1:0] s);
		int n;
		int t;
		dir = b2a;
		sel = s;
		len = 16'(FREQ / BAUD_TABLE[s]);
		n = 0;
		t = 0;
		go_a = ~b2a;
		go_b = b2a;
		@(negedge clock_i);
		go_a = 1'b0;
		go_b = 1'b0;
		while ((b2a ? en_a : en_b) !== 1'b1 && t < 20) begin
			@(negedge clock_i);
			t++;
		end
		while ((b2a ? en_a : en_b) === 1'b1 && n < 20000) begin
			if (n == 0) cmp("remain at start", len * FRAME_BITS - 1, remain);
			cmp("tx copy", src_q, b2a ? tx_a : tx_b);
			cmp("origin driver", 1'b0, b2a ? en_b : en_a);
			n++;
			@(negedge clock_i);
		end
		cmp("driver cycles", len * FRAME_BITS, n);
		cmp("idle", 24'h0, {en_a, en_b, ~tx_a, ~tx_b, remain});
		repeat (3) @(negedge clock_i);
	endtask : xfer
	// Both sides start together: A wins, B is not forwarded, a selector move mid character is ignored
	task automatic tie_start();
		int n;
		dir = 1'b0;
		sel = 3'h7;
		len = 16'(FREQ / BAUD_TABLE[7]);
		n = 0;
		go_a = 1'b1;
		go_b = 1'b1;
		@(negedge clock_i);
		go_a = 1'b0;
		go_b = 1'b0;
		@(negedge clock_i);
		while (en_b === 1'b1 && n < 2000) begin
			cmp("tie tx copy", src_q, tx_b);
			cmp("tie loser driver", 1'b0, en_a);
			if (n == 20) sel = 3'h0;
			n++;
			@(negedge clock_i);
		end
		cmp("tie driver cycles", len * FRAME_BITS, n);
		cmp("tie idle", 24'h0, {en_a, en_b, ~tx_a, ~tx_b, remain});
		repeat (3) @(negedge clock_i);
	endtask : tie_start
	// Reset in mid character drops the driver at once; release waits until the sending node is idle
	task automatic reset_mid();
		dir = 1'b1;
		sel = 3'h7;
		len = 16'(FREQ / BAUD_TABLE[7]);
		go_b = 1'b1;
		@(negedge clock_i);
		go_b = 1'b0;
		repeat (20) @(negedge clock_i);
		cmp("driver before reset", 1'b1, en_a);
		rst_n_i = 1'b0;
		@(negedge clock_i);
		cmp("driver in reset", 24'h0, {en_a, en_b, ~tx_a, ~tx_b, remain});
		repeat (90) @(negedge clock_i);
		rst_n_i = 1'b1;
		@(negedge clock_i);
		cmp("idle after reset", 24'h0, {en_a, en_b, ~tx_a, ~tx_b, remain});
		repeat (3) @(negedge clock_i);
	endtask : reset_mid
	task automatic end_of_test();
		if (fail_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	// Watchdog well beyond the longest run of characters
	initial begin
		#2400000;
		fail_count++;
		end_of_test();
	end
	initial begin
		fail_count = 0;
		checked = 0;
		{go_a, go_b, dir, rst_n_i} = 4'h0;
		sel = SEL_RST;
		len = 16'h0001;
		repeat (8) @(negedge clock_i);
		rst_n_i = 1'b1;
		@(negedge clock_i);
		cmp("reset idle", 24'h0, {en_a, en_b, ~tx_a, ~tx_b, remain});
		for (int s = 0; s < NUM_RATES; s++) xfer(1'b0, s[SEL_W-1:0]);
		xfer(1'b1, 3'h7);
		tie_start();
		reset_mid();
		xfer(1'b1, 3'h0);
		end_of_test();
	end
endmodule : rsrep_core_tb
`default_nettype wire
